// file: rtl/arp_regs.vh
`ifndef ARP_REGS_VH
`define ARP_REGS_VH

// register indices; byte address is four times the index
`define ARP_IDX_THOLD     7'h35
`define ARP_IDX_MASK_HI   7'h36
`define ARP_IDX_PROC      7'h37
`define ARP_IDX_CRST_LO   7'h38
`define ARP_IDX_SYSRST    7'h39
`define ARP_IDX_DRVPD_LO  7'h3a
`define ARP_IDX_TXPD      7'h3b
`define ARP_IDX_GLBPD     7'h3c
`define ARP_IDX_RATE      7'h50
`define ARP_IDX_STATUS    7'h51

// reset values
`define ARP_RST_ZERO      8'h00
`define ARP_RST_PROC      8'h02
`define ARP_RST_GLBPD     8'h80

// fields of the procedure control register
`define ARP_PROC_CYC_HI   7
`define ARP_PROC_CYC_LO   5
`define ARP_PROC_AUTOPD   4
`define ARP_PROC_BKGND    3
`define ARP_PROC_SERIAL   2
`define ARP_PROC_REDUCE   1
`define ARP_PROC_ITER     0

// fields of the system reset register
`define ARP_SYS_DIGRST    7
`define ARP_SYS_ALLCH     6

// base time-stamp count and counter width
`define ARP_TS_BASE       29'h00000040
`define ARP_TS_W          29

`endif

// file: rtl/arp_regbank.v
`timescale 1ns/1ns
`include "arp_regs.vh"

module arp_regbank (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        clk_en,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        ts_strobe,
   input  wire [5:0]  misalign,
   output reg  [9:0]  align_channel_mask,
   output reg  [5:0]  align_threshold,
   output reg         align_busy,
   output reg  [3:0]  align_channel,
   output reg  [28:0] timestamp_count,
   output reg         system_digital_reset,
   output reg  [9:0]  chan_reset,
   output reg  [9:0]  driver_off,
   output reg  [5:0]  tx_path_off,
   output reg  [7:0]  global_pd
);

   // sequencer states
   localparam [1:0] S_IDLE = 2'b00;
   localparam [1:0] S_SCAN = 2'b01;
   localparam [1:0] S_RUN  = 2'b10;
   localparam [1:0] S_NEXT = 2'b11;

   reg  [7:0]  thold_reg;
   reg  [7:0]  mask_hi_reg;
   reg  [7:0]  proc_reg;
   reg  [7:0]  crst_lo_reg;
   reg  [7:0]  sysrst_reg;
   reg  [7:0]  drvpd_lo_reg;
   reg  [7:0]  txpd_reg;
   reg  [7:0]  glbpd_reg;
   reg  [7:0]  rate_reg;
   reg  [1:0]  state_reg;
   reg  [1:0]  state_next;
   reg  [3:0]  chan_reg;
   reg  [3:0]  chan_next;
   reg  [2:0]  cyc_reg;
   reg  [2:0]  cyc_next;
   reg  [28:0] cnt_reg;
   reg  [28:0] cnt_next;
   reg  [28:0] target_reg;
   reg  [28:0] target_next;
   reg         bg_reg;
   reg         bg_next;
   reg  [31:0] rd_next;
   reg         hit_next;
   reg  [3:0]  first_exp;

   wire [6:0]  idx;
   wire        setup;
   wire        wr_now;
   wire [9:0]  mask_all;
   wire [9:0]  crst_all;
   wire [9:0]  drvpd_all;
   wire [2:0]  cyc_max;
   wire        reduce_on;
   wire        iter_on;
   wire        autopd_on;
   wire        serial_start;
   wire        digrst;
   wire [3:0]  dec_rate;
   wire [3:0]  avg_exp;
   wire        last_cycle;
   wire        below_thold;
   wire        busy_next;

   // apb decode; the address is a word index, byte lanes 1..3 ignored
   assign idx    = paddr[8:2];
   assign setup  = psel & ~penable;
   assign wr_now = psel & penable & pready & pwrite & ~pslverr;

   // split fields, low bits in the lower address
   assign mask_all  = {mask_hi_reg, thold_reg[7:6]};
   assign crst_all  = {sysrst_reg[1:0], crst_lo_reg};
   assign drvpd_all = {txpd_reg[1:0], drvpd_lo_reg};

   assign cyc_max   = proc_reg[`ARP_PROC_CYC_HI:`ARP_PROC_CYC_LO];
   assign reduce_on = proc_reg[`ARP_PROC_REDUCE];
   assign iter_on   = proc_reg[`ARP_PROC_ITER];
   assign autopd_on = proc_reg[`ARP_PROC_AUTOPD];
   assign digrst    = sysrst_reg[`ARP_SYS_DIGRST];
   assign dec_rate  = rate_reg[3:0];
   assign avg_exp   = rate_reg[7:4];

   // a write that carries a 1 in the serial enable starts a run
   assign serial_start = wr_now & (idx == `ARP_IDX_PROC) & pwdata[`ARP_PROC_SERIAL];

   // the count field is cycles minus one, so code 111 is the eighth cycle
   assign last_cycle  = (cyc_reg == cyc_max);
   assign below_thold = (misalign < thold_reg[5:0]);

   // busy as it stands after this edge; the auto-disable uses it so drivers follow busy exactly
   assign busy_next = (state_next == S_RUN) & ~digrst;

   // exponent of the first cycle in reduced mode, floored at zero
   always @* begin
      if (avg_exp > {1'b0, cyc_max}) begin
         first_exp = avg_exp - {1'b0, cyc_max};
      end else begin
         first_exp = 4'h0;
      end
   end

   // apb read mux and unmapped detection, prepared in the setup cycle
   always @* begin
      rd_next  = 32'h00000000;
      hit_next = 1'b1;
      case (idx)
         `ARP_IDX_THOLD:    rd_next = {24'h000000, thold_reg};
         `ARP_IDX_MASK_HI:  rd_next = {24'h000000, mask_hi_reg};
         `ARP_IDX_PROC:     rd_next = {24'h000000, proc_reg};
         `ARP_IDX_CRST_LO:  rd_next = {24'h000000, crst_lo_reg};
         `ARP_IDX_SYSRST:   rd_next = {24'h000000, sysrst_reg};
         `ARP_IDX_DRVPD_LO: rd_next = {24'h000000, drvpd_lo_reg};
         `ARP_IDX_TXPD:     rd_next = {24'h000000, txpd_reg};
         `ARP_IDX_GLBPD:    rd_next = {24'h000000, glbpd_reg};
         `ARP_IDX_RATE:     rd_next = {24'h000000, rate_reg};
         `ARP_IDX_STATUS:   rd_next = {22'h000000, cyc_reg, chan_reg, below_thold, bg_reg, align_busy};
         default:           hit_next = 1'b0;
      endcase
      if (paddr[11:9] != 3'h0) begin
         hit_next = 1'b0;
      end
   end

   // every register sits in flops, so the answer is always ready one cycle after setup
   // bus handshake: one wait-free access phase, pready raised for it only
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else if (clk_en) begin
         pready  <= setup;
         pslverr <= setup & ~hit_next;
         if (setup & ~pwrite & hit_next) begin
            prdata <= rd_next;
         end else if (setup) begin
            prdata <= 32'h00000000; // unmapped reads return zero
         end
      end
   end

   // the status word falls to the default arm and changes nothing; refused indices never raise wr_now
   // register file; each byte register is written on its own
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         thold_reg    <= `ARP_RST_ZERO;
         mask_hi_reg  <= `ARP_RST_ZERO;
         proc_reg     <= `ARP_RST_PROC;
         crst_lo_reg  <= `ARP_RST_ZERO;
         sysrst_reg   <= `ARP_RST_ZERO;
         drvpd_lo_reg <= `ARP_RST_ZERO;
         txpd_reg     <= `ARP_RST_ZERO;
         glbpd_reg    <= `ARP_RST_GLBPD;
         rate_reg     <= `ARP_RST_ZERO;
      end else if (clk_en && wr_now) begin
         case (idx)
            `ARP_IDX_THOLD:    thold_reg    <= pwdata[7:0];
            `ARP_IDX_MASK_HI:  mask_hi_reg  <= pwdata[7:0];
            `ARP_IDX_PROC:     proc_reg     <= pwdata[7:0];
            `ARP_IDX_CRST_LO:  crst_lo_reg  <= pwdata[7:0];
            `ARP_IDX_SYSRST:   sysrst_reg   <= pwdata[7:0]; // reserved bits kept as written
            `ARP_IDX_DRVPD_LO: drvpd_lo_reg <= pwdata[7:0];
            `ARP_IDX_TXPD:     txpd_reg     <= pwdata[7:0];
            `ARP_IDX_GLBPD:    glbpd_reg    <= pwdata[7:0];
            `ARP_IDX_RATE:     rate_reg     <= pwdata[7:0];
            default:           rate_reg     <= rate_reg;
         endcase
      end
   end

   // alignment sequencer: walk the masked channels, count stamps per cycle
   always @* begin
      state_next  = state_reg;
      chan_next   = chan_reg;
      cyc_next    = cyc_reg;
      cnt_next    = cnt_reg;
      target_next = target_reg;
      bg_next     = bg_reg;
      case (state_reg)
         S_IDLE: begin
            chan_next = 4'h0;
            if (serial_start) begin
               state_next = S_SCAN;
               bg_next    = 1'b0;
            end else if (proc_reg[`ARP_PROC_BKGND]) begin
               state_next = S_SCAN;
               bg_next    = 1'b1;
            end
         end
         S_SCAN: begin
            // unmasked channels cost one cycle each, which is why busy may rise late
            cyc_next = 3'h0;
            cnt_next = {`ARP_TS_W{1'b0}};
            if (reduce_on) begin
               target_next = `ARP_TS_BASE << first_exp;
            end else begin
               target_next = `ARP_TS_BASE << dec_rate;
            end
            if (mask_all[chan_reg]) begin
               state_next = S_RUN;
            end else if (chan_reg == 4'h9) begin
               state_next = S_IDLE;
            end else begin
               chan_next = chan_reg + 4'h1;
            end
         end
         S_RUN: begin
            // stamps may arrive with gaps, so only strobes advance the count
            if (ts_strobe) begin
               cnt_next = cnt_reg + 29'h00000001;
            end
            if (ts_strobe && (cnt_reg == target_reg - 29'h00000001)) begin
               state_next = S_NEXT;
            end
         end
         S_NEXT: begin
            cnt_next = {`ARP_TS_W{1'b0}};
            if (last_cycle || (iter_on && below_thold)) begin
               // channel finished; stop early once aligned inside the threshold
               if (chan_reg == 4'h9) begin
                  state_next = S_IDLE;
               end else begin
                  chan_next  = chan_reg + 4'h1;
                  state_next = S_SCAN;
               end
            end else begin
               cyc_next   = cyc_reg + 3'h1;
               state_next = S_RUN;
               if (reduce_on) begin
                  target_next = target_reg << 1;
               end
            end
         end
         default: begin
            state_next = S_IDLE;
         end
      endcase
      // background mode stops as soon as its enable is cleared
      if (bg_reg && !proc_reg[`ARP_PROC_BKGND] && (state_reg != S_IDLE)) begin
         state_next = S_IDLE;
      end
   end

   // sequencer state; the digital reset bit holds it at its power-on state
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg  <= S_IDLE;
         chan_reg   <= 4'h0;
         cyc_reg    <= 3'h0;
         cnt_reg    <= {`ARP_TS_W{1'b0}};
         target_reg <= {`ARP_TS_W{1'b0}};
         bg_reg     <= 1'b0;
      end else if (clk_en) begin
         if (digrst) begin
            state_reg  <= S_IDLE;
            chan_reg   <= 4'h0;
            cyc_reg    <= 3'h0;
            cnt_reg    <= {`ARP_TS_W{1'b0}};
            target_reg <= {`ARP_TS_W{1'b0}};
            bg_reg     <= 1'b0;
         end else begin
            state_reg  <= state_next;
            chan_reg   <= chan_next;
            cyc_reg    <= cyc_next;
            cnt_reg    <= cnt_next;
            target_reg <= target_next;
            bg_reg     <= bg_next;
         end
      end
   end

   // registered outputs toward the channel and alignment hardware
   // outputs lag their source by one edge; busy, channel, stamp count and the auto-disable look ahead
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         align_channel_mask   <= 10'h000;
         align_threshold      <= 6'h00;
         align_busy           <= 1'b0;
         align_channel        <= 4'h0;
         timestamp_count      <= {`ARP_TS_W{1'b0}};
         system_digital_reset <= 1'b0;
         global_pd            <= `ARP_RST_GLBPD;
      end else if (clk_en) begin
         align_channel_mask   <= mask_all;
         align_threshold      <= thold_reg[5:0];
         align_busy           <= busy_next;
         align_channel        <= chan_next;
         timestamp_count      <= target_next;
         system_digital_reset <= digrst;
         global_pd            <= glbpd_reg;
      end
   end

   // per-channel controls, one slice per channel
   genvar ch;
   generate
      for (ch = 0; ch < 10; ch = ch + 1) begin : g_chan
         wire idle_drv;
         wire path_pd;
         // a driver counts as idle during alignment unless it is the channel in use
         assign idle_drv = autopd_on & busy_next & (chan_next != ch);
         // only channels 0 to 5 own a transmit path bit; the rest keep their path powered
         if (ch < 6) begin : g_path
            assign path_pd = txpd_reg[ch + 2];
         end else begin : g_nopath
            assign path_pd = 1'b0;
         end
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               chan_reset[ch] <= 1'b0;
               driver_off[ch] <= 1'b0;
            end else if (clk_en) begin
               chan_reset[ch] <= crst_all[ch] | sysrst_reg[`ARP_SYS_ALLCH];
               driver_off[ch] <= drvpd_all[ch] | path_pd | idle_drv;
            end
         end
         if (ch < 6) begin : g_txo
            always @(posedge pclk or negedge presetn) begin
               if (!presetn) begin
                  tx_path_off[ch] <= 1'b0;
               end else if (clk_en) begin
                  tx_path_off[ch] <= path_pd;
               end
            end
         end
      end
   endgenerate

endmodule // arp_regbank

// file: testbench/arp_regbank_properties.sv
`timescale 1ns/1ns
module arp_regbank_properties (
   input wire        pclk,
   input wire        presetn,
   input wire        clk_en,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire        align_busy,
   input wire [28:0] timestamp_count,
   input wire        system_digital_reset,
   input wire [9:0]  driver_off,
   input wire [5:0]  tx_path_off,
   input wire [7:0]  global_pd
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // bus answers with a single-cycle strobe right after the setup cycle
   property p_rdy_setup; psel && !penable && clk_en |=> pready; endproperty
   a_rdy_setup: assert property (p_rdy_setup) else $error("no answer after setup");
   property p_rdy_once; pready |=> !pready; endproperty
   a_rdy_once: assert property (p_rdy_once) else $error("pready held");
   property p_err_rdy; pslverr |-> pready; endproperty
   a_err_rdy: assert property (p_err_rdy) else $error("error without pready");
   // byte registers read zero in the upper lanes, but the 10-bit status word puts cycle bits in 9:7
   property p_rdata_hi; pready && !pwrite |-> prdata[31:8] == 24'h000000; endproperty
   a_rdata_hi: assert property (p_rdata_hi) else $error("upper read lanes set");
   // a dead transmit path always takes its driver down with it
   property p_txpath_drv; (tx_path_off & ~driver_off[5:0]) == 6'h00; endproperty
   a_txpath_drv: assert property (p_txpath_drv) else $error("driver on with path off");
   property p_sysrst_idle; system_digital_reset [*3] |-> !align_busy; endproperty
   a_sysrst_idle: assert property (p_sysrst_idle) else $error("busy in system reset");
   // stamp target is 64 times a power of two while busy
   property p_ts_pow2; align_busy |-> $onehot(timestamp_count) && timestamp_count >= 29'h40; endproperty
   a_ts_pow2: assert property (p_ts_pow2) else $error("bad stamp target");
   property p_glbpd_wr; $changed(global_pd) |-> $past(psel && penable && pwrite, 2); endproperty
   a_glbpd_wr: assert property (p_glbpd_wr) else $error("global pd moved alone");
endmodule // arp_regbank_properties

bind arp_regbank arp_regbank_properties arp_regbank_properties_i (
   .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
   .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr), .align_busy(align_busy),
   .timestamp_count(timestamp_count), .system_digital_reset(system_digital_reset),
   .driver_off(driver_off), .tx_path_off(tx_path_off), .global_pd(global_pd));

// file: testbench/arp_engine_model.sv
`timescale 1ns/1ns
module arp_engine_model (
   input wire       pclk,
   input wire       presetn,
   input wire       align_busy,
   input wire [3:0] gap,
   input wire [5:0] mis_set,
   output reg       ts_strobe,
   output reg [5:0] misalign
);
   reg [3:0] cnt_reg;
   // one stamp every gap cycles while busy; a slow gap shows cycles are not counted as stamps
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg   <= 4'h0;
         ts_strobe <= 1'b0;
         misalign  <= 6'h00;
      end else begin
         misalign  <= mis_set;
         ts_strobe <= align_busy && (cnt_reg == gap - 4'h1);
         cnt_reg   <= (align_busy && cnt_reg != gap - 4'h1) ? cnt_reg + 4'h1 : 4'h0;
      end
   end
endmodule // arp_engine_model

// file: testbench/arp_regbank_tb_top.sv
`timescale 1ns/1ns
module arp_regbank_tb_top;
   reg         pclk, presetn, psel, penable, pwrite, err;
   reg  [11:0] paddr;
   reg  [31:0] pwdata, lf, rd;
   reg  [3:0]  gap;
   reg  [5:0]  mis;
   reg  [7:0]  sh [53:60];
   wire [31:0] prdata;
   wire        pready, pslverr, ts_strobe, align_busy, sdr;
   wire [5:0]  misalign, align_threshold, tx_path_off;
   wire [9:0]  align_channel_mask, chan_reset, driver_off;
   wire [3:0]  align_channel;
   wire [28:0] timestamp_count;
   wire [7:0]  global_pd;
   integer     error_cnt, comparisons, cyc, i, r;

   arp_regbank arp_regbank_i (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ts_strobe(ts_strobe), .misalign(misalign),
      .align_channel_mask(align_channel_mask), .align_threshold(align_threshold),
      .align_busy(align_busy), .align_channel(align_channel), .timestamp_count(timestamp_count),
      .system_digital_reset(sdr), .chan_reset(chan_reset), .driver_off(driver_off),
      .tx_path_off(tx_path_off), .global_pd(global_pd));
   arp_engine_model arp_engine_model_i (.pclk(pclk), .presetn(presetn), .align_busy(align_busy),
      .gap(gap), .mis_set(mis), .ts_strobe(ts_strobe), .misalign(misalign));

   // clock and a hang guard
   always #4 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         error_cnt = error_cnt + 1;
         end_of_test;
      end
   end

   function [31:0] nx(input [31:0] s);
      nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // driver state from the power-down bytes, plus idle channels when auto-disable is active
   function [9:0] exp_drv(input [3:0] ch, input on);
      exp_drv = {sh[59][1:0], sh[58]} | {4'h0, sh[59][7:2]} | (on ? ~(10'h001 << ch) : 10'h000);
   endfunction

   task check(input [31:0] seen, input [31:0] exp);
      begin
         comparisons = comparisons + 1;
         if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   // one transfer; the request stays put until pready is sampled high
   task xfer(input w, input [6:0] idx, input [7:0] d);
      begin
         @(posedge pclk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= {3'b000, idx, 2'b00};
         pwdata <= {lf[31:8], d};
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         while (pready !== 1'b1) @(posedge pclk);
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task chk_out;
      begin
         repeat (2) @(posedge pclk);
         #1;
         check(align_channel_mask, {sh[54], sh[53][7:6]});
         check(align_threshold, sh[53][5:0]);
         check(chan_reset, {sh[57][1:0], sh[56]} | {10{sh[57][6]}});
         check(sdr, sh[57][7]);
         check(driver_off, exp_drv(4'h0, 1'b0));
         check(tx_path_off, sh[59][7:2]);
         check(global_pd, sh[60]);
      end
   endtask
   // start a run and watch every alignment cycle until the sequencer goes quiet
   task run(input [9:0] m, input [7:0] p, input integer n, input [28:0] t0, input dbl);
      integer k, seen, idle;
      reg [28:0] t;
      reg pb;
      begin
         sh[53] = {m[1:0], 6'h05};
         sh[54] = m[9:2];
         xfer(1, 7'h35, sh[53]);
         xfer(1, 7'h36, sh[54]);
         xfer(1, 7'h37, p);
         t = t0;
         seen = 0;
         idle = 0;
         pb = 0;
         for (k = 0; k < 6000 && idle < 30; k = k + 1) begin
            @(posedge pclk);
            #1;
            idle = align_busy ? 0 : idle + 1;
            if (align_busy && !pb) begin
               seen = seen + 1;
               check(timestamp_count, t);
               check(m[align_channel], 1'b1);
               check(driver_off, exp_drv(align_channel, p[4]));
               if (dbl) t = t << 1;
            end
            pb = align_busy;
         end
         check(seen, n);
      end
   endtask
   task wait_busy(input v);
      integer k;
      begin
         for (k = 0; k < 40 && align_busy !== v; k = k + 1) @(posedge pclk);
         #1;
         check(align_busy, v);
      end
   endtask
   task end_of_test;
      begin
         $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
         if (error_cnt == 0 && comparisons > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask

   initial begin
      pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
      lf = 32'hb65d15c0; gap = 4'h1; mis = 6'h00; error_cnt = 0; comparisons = 0; cyc = 0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      for (i = 53; i <= 60; i = i + 1) begin
         xfer(0, i[6:0], 8'h00);
         check(rd, i == 55 ? 32'h02 : (i == 60 ? 32'h80 : 32'h00));
      end
      // random bytes in every writable register but the rate, reserved bits too; start bits kept clear
      for (r = 0; r < 4; r = r + 1) begin
         for (i = 53; i <= 60; i = i + 1) begin
            lf = nx(lf);
            sh[i] = (i == 55) ? (lf[7:0] & 8'hf3) : lf[7:0];
            xfer(1, i[6:0], sh[i]);
         end
         for (i = 53; i <= 60; i = i + 1) begin
            xfer(0, i[6:0], 8'h00);
            check(rd, sh[i]);
         end
         chk_out;
      end
      xfer(0, 7'h40, 8'h00);
      check(err, 1'b1);
      check(rd, 32'h0);
      // host setup: transmit paths down, channel and system resets released
      sh[56] = 8'h00; sh[57] = 8'h00; sh[58] = 8'h00; sh[59] = 8'hfc;
      for (i = 56; i <= 59; i = i + 1) xfer(1, i[6:0], sh[i]);
      xfer(1, 7'h50, 8'h01);
      gap <= 4'h2;
      run(10'h201, 8'h34, 4, 29'd128, 0);
      xfer(1, 7'h50, 8'h40);
      xfer(0, 7'h50, 8'h00);
      check(rd, 32'h40);
      gap <= 4'h1;
      run(10'h008, 8'h46, 3, 29'd256, 1);
      xfer(1, 7'h50, 8'h00);
      run(10'h004, 8'h65, 1, 29'd64, 0);
      mis <= 6'h3f;
      run(10'h004, 8'h65, 4, 29'd64, 0);
      run(10'h002, 8'he4, 8, 29'd64, 0);
      run(10'h100, 8'h04, 1, 29'd64, 0);
      // system reset holds the sequencer idle
      sh[57] = 8'h80;
      xfer(1, 7'h39, 8'h80);
      run(10'h002, 8'h04, 0, 29'd64, 0);
      xfer(1, 7'h37, 8'h00);
      xfer(1, 7'h39, 8'h00);
      xfer(1, 7'h37, 8'h08);
      wait_busy(1'b1);
      xfer(1, 7'h37, 8'h00);
      wait_busy(1'b0);
      end_of_test;
   end
endmodule // arp_regbank_tb_top
